// ### logic/ncs_pkg.sv
// Purpose: Shared constants and types for oscillator select and overrange pin logic
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes: Register offsets are byte addresses
package ncs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_CHAN = 2;
  localparam int unsigned NUM_OSC = 4;
  localparam int unsigned NUM_FLAG = 4;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned PHASE_W = 32;
  localparam int unsigned PULSE_W = 8;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_THRESH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PULSE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FREQ_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_FREQ_LAST = 8'h3c;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int unsigned THR_SECOND_LSB = 16;
  localparam int unsigned STATE_SEL_B_LSB = 2;
  localparam int unsigned STATE_FLAG_LSB = 4;
  localparam int unsigned STATE_PD_BIT = 8;

  typedef struct packed {
    logic link_output_mode;
    logic pin_osc_select_enable;
  } ncs_ctrl_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] second;
    logic [SAMPLE_W-1:0] first;
  } ncs_thresh_t;

  localparam ncs_ctrl_t CTRL_RESET = 2'h0;
  localparam logic [SAMPLE_W-1:0] THR_RESET = 12'h7ff;
  localparam logic [PULSE_W-1:0] PULSE_RESET = 8'h01;
  localparam logic [PULSE_W-1:0] PULSE_ONE = 8'h01;
  localparam logic [PHASE_W-1:0] FREQ_RESET = 32'h00000000;
endpackage : ncs_pkg

// ### logic/ncs_top.sv
// Purpose: Oscillator bank selection, overrange flags and power-down pin handling
// Assumes: Samples arrive on aclk; select and power-down pins are asynchronous
// Notes: Registers over AXI4-Lite; one level interrupt from sticky overrange events
`timescale 1ns/10ps

module ncs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ncs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ncs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ncs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ncs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chan_a_osc_sel_lsb,
  input wire logic chan_a_osc_sel_msb,
  input wire logic chan_b_osc_sel_lsb,
  input wire logic chan_b_osc_sel_msb,
  input wire logic power_down_in,
  input wire logic signed [ncs_pkg::SAMPLE_W-1:0] sample_a,
  input wire logic signed [ncs_pkg::SAMPLE_W-1:0] sample_b,
  output logic [1:0] active_osc_a,
  output logic [1:0] active_osc_b,
  output logic [ncs_pkg::PHASE_W-1:0] mix_phase_a,
  output logic [ncs_pkg::PHASE_W-1:0] mix_phase_b,
  output logic mix_enable_a,
  output logic mix_enable_b,
  output logic chan_a_over_flag_first,
  output logic chan_a_over_flag_second,
  output logic chan_b_over_flag_first,
  output logic chan_b_over_flag_second,
  output logic analog_enable,
  output logic serializer_enable,
  output logic irq
);
  localparam int unsigned NF = ncs_pkg::NUM_FLAG;

  ncs_pkg::ncs_ctrl_t ctrl;
  ncs_pkg::ncs_thresh_t thresh;
  logic [ncs_pkg::PULSE_W-1:0] over_min_pulse_len;
  logic [NF-1:0] status;
  logic [NF-1:0] irq_enable;
  logic [ncs_pkg::PHASE_W-1:0] freq [ncs_pkg::NUM_CHAN*ncs_pkg::NUM_OSC];
  logic [ncs_pkg::PHASE_W-1:0] acc [ncs_pkg::NUM_CHAN*ncs_pkg::NUM_OSC];

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_freq(input logic [ncs_pkg::ADDR_W-1:0] a);
    is_freq = (a >= ncs_pkg::OFF_FREQ_BASE) && (a <= ncs_pkg::OFF_FREQ_LAST);
  endfunction : is_freq

  function automatic logic [2:0] freq_idx(input logic [ncs_pkg::ADDR_W-1:0] a);
    logic [ncs_pkg::ADDR_W-1:0] d;
    d = a - ncs_pkg::OFF_FREQ_BASE;
    freq_idx = d[4:2];
  endfunction : freq_idx

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction : merge

  function automatic logic [ncs_pkg::SAMPLE_W-1:0] mag(
      input logic [ncs_pkg::SAMPLE_W-1:0] s);
    mag = s[ncs_pkg::SAMPLE_W-1] ? (~s + 12'h001) : s;
  endfunction : mag

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [ncs_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [NF-1:0] irq_clear;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ncs_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[1:0] == 2'h0 && (is_freq(aw_addr) ||
                      aw_addr <= ncs_pkg::OFF_IRQ_ENABLE) && aw_addr != ncs_pkg::OFF_STATUS)
                     ? ncs_pkg::RESP_OKAY : ncs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= ncs_pkg::CTRL_RESET;
      thresh <= {ncs_pkg::THR_RESET, ncs_pkg::THR_RESET};
      over_min_pulse_len <= ncs_pkg::PULSE_RESET;
      irq_enable <= '0;
      for (int i = 0; i < ncs_pkg::NUM_CHAN*ncs_pkg::NUM_OSC; i++) begin
        freq[i] <= ncs_pkg::FREQ_RESET;
      end
    end else if (do_write) begin
      case (aw_addr)
        ncs_pkg::OFF_CTRL: ctrl <= 2'(merge({30'h0, ctrl}, w_data, w_strb) & 32'h3);
        ncs_pkg::OFF_THRESH: begin
          thresh.first <= 12'(merge({20'h0, thresh.first}, w_data, w_strb) & 32'hfff);
          thresh.second <= 12'(merge({20'h0, thresh.second},
                                     w_data >> ncs_pkg::THR_SECOND_LSB,
                                     w_strb >> 2) & 32'hfff);
        end
        ncs_pkg::OFF_PULSE: over_min_pulse_len <= 8'(merge({24'h0, over_min_pulse_len},
                                                           w_data, w_strb) & 32'hff);
        ncs_pkg::OFF_IRQ_ENABLE: irq_enable <= NF'(merge({28'h0, irq_enable}, w_data,
                                                         w_strb) & 32'hf);
        default: begin
          // Unaligned word answers an error and must leave the bank untouched
          if (is_freq(aw_addr) && aw_addr[1:0] == 2'h0) begin
            freq[freq_idx(aw_addr)] <= merge(freq[freq_idx(aw_addr)], w_data, w_strb);
          end
        end
      endcase
    end
  end

  assign irq_clear = (do_write && aw_addr == ncs_pkg::OFF_IRQ_CLEAR && w_strb[0])
                     ? w_data[NF-1:0] : '0;

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  logic [31:0] rd_value;
  logic rd_ok;
  logic [NF-1:0] flags;

  always_comb begin
    rd_value = 32'h0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      ncs_pkg::OFF_CTRL: rd_value = {30'h0, ctrl};
      ncs_pkg::OFF_THRESH: rd_value = {4'h0, thresh.second, 4'h0, thresh.first};
      ncs_pkg::OFF_PULSE: rd_value = {24'h0, over_min_pulse_len};
      ncs_pkg::OFF_STATUS: rd_value = {28'h0, status};
      ncs_pkg::OFF_IRQ_CLEAR: rd_value = 32'h0;
      ncs_pkg::OFF_IRQ_ENABLE: rd_value = {28'h0, irq_enable};
      ncs_pkg::OFF_STATE: begin
        rd_value[1:0] = active_osc_a;
        rd_value[ncs_pkg::STATE_SEL_B_LSB +: 2] = active_osc_b;
        rd_value[ncs_pkg::STATE_FLAG_LSB +: NF] = flags;
        rd_value[ncs_pkg::STATE_PD_BIT] = !analog_enable;
      end
      default: begin
        if (is_freq(s_axi_araddr) && s_axi_araddr[1:0] == 2'h0) begin
          rd_value = freq[freq_idx(s_axi_araddr)];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ncs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_ok ? ncs_pkg::RESP_OKAY : ncs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Pin synchronizers
  // ****************************************
  logic [1:0] sel_meta [ncs_pkg::NUM_CHAN];
  logic [1:0] sel_sync [ncs_pkg::NUM_CHAN];
  logic [1:0] sel_prev [ncs_pkg::NUM_CHAN];
  logic [1:0] active [ncs_pkg::NUM_CHAN];
  logic pd_meta;
  logic pd_sync;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_meta[0] <= '0;
      sel_meta[1] <= '0;
      sel_sync[0] <= '0;
      sel_sync[1] <= '0;
      pd_meta <= 1'b0;
      pd_sync <= 1'b0;
    end else begin
      sel_meta[0] <= {chan_a_osc_sel_msb, chan_a_osc_sel_lsb};
      sel_meta[1] <= {chan_b_osc_sel_msb, chan_b_osc_sel_lsb};
      sel_sync[0] <= sel_meta[0];
      sel_sync[1] <= sel_meta[1];
      pd_meta <= power_down_in;
      pd_sync <= pd_meta;
    end
  end

  // ****************************************
  // Oscillator bank
  // ****************************************
  // Pair must agree on two samples so a skewed two-bit change never selects a stray bank
  generate
    for (genvar c = 0; c < ncs_pkg::NUM_CHAN; c++) begin : g_chan
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sel_prev[c] <= '0;
          active[c] <= '0;
        end else begin
          sel_prev[c] <= sel_sync[c];
          if (ctrl.pin_osc_select_enable && sel_sync[c] == sel_prev[c]) begin
            active[c] <= sel_sync[c];
          end
        end
      end

      sel_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl.pin_osc_select_enable |=> $stable(active[c]))
        else $error("oscillator index changed with pin select disabled");

      sel_settle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !$stable(active[c]) |-> $past(sel_sync[c]) == $past(sel_prev[c]) &&
                                active[c] == $past(sel_sync[c]))
        else $error("oscillator index took an unsettled select value");
    end

    for (genvar k = 0; k < ncs_pkg::NUM_CHAN*ncs_pkg::NUM_OSC; k++) begin : g_osc
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          acc[k] <= '0;
        end else begin
          acc[k] <= acc[k] + freq[k];
        end
      end

      phase_adv_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 acc[k] == $past(acc[k]) + $past(freq[k]))
        else $error("oscillator phase did not advance");
    end
  endgenerate

  assign active_osc_a = active[0];
  assign active_osc_b = active[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mix_phase_a <= '0;
      mix_phase_b <= '0;
      mix_enable_a <= 1'b0;
      mix_enable_b <= 1'b0;
    end else begin
      mix_phase_a <= acc[{1'b0, active[0]}];
      mix_phase_b <= acc[{1'b1, active[1]}];
      mix_enable_a <= ctrl.link_output_mode && !pd_sync;
      mix_enable_b <= ctrl.link_output_mode && !pd_sync;
    end
  end

  mix_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mix_enable_a |-> $past(ctrl.link_output_mode) && mix_enable_a == mix_enable_b)
    else $error("mixing enabled outside complex output mode");

  // ****************************************
  // Power-down
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_enable <= 1'b1;
      serializer_enable <= 1'b1;
    end else begin
      analog_enable <= !pd_sync;
      serializer_enable <= !pd_sync;
    end
  end

  pd_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 analog_enable == !$past(pd_sync) && serializer_enable == analog_enable)
    else $error("analog or serializer enable does not follow power-down");

  // ****************************************
  // Overrange flags
  // ****************************************
  // Flag f: bit 1 picks channel, bit 0 picks threshold
  logic [ncs_pkg::PULSE_W-1:0] hold_cnt [NF];
  logic [NF-1:0] exceed;
  logic [ncs_pkg::PULSE_W-1:0] load_len;

  assign load_len = (over_min_pulse_len == '0) ? ncs_pkg::PULSE_ONE : over_min_pulse_len;

  generate
    for (genvar f = 0; f < NF; f++) begin : g_flag
      assign exceed[f] = mag((f / 2 == 0) ? sample_a : sample_b) >
                         ((f % 2 == 0) ? thresh.first : thresh.second);

      always_ff @(posedge aclk) begin
        if (!aresetn || pd_sync) begin
          hold_cnt[f] <= '0;
          flags[f] <= 1'b0;
        end else if (exceed[f]) begin
          hold_cnt[f] <= load_len;
          flags[f] <= 1'b1;
        end else if (hold_cnt[f] > ncs_pkg::PULSE_ONE) begin
          hold_cnt[f] <= hold_cnt[f] - ncs_pkg::PULSE_ONE;
          flags[f] <= 1'b1;
        end else begin
          hold_cnt[f] <= '0;
          flags[f] <= 1'b0;
        end
      end

      flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn || pd_sync)
        exceed[f] |=> flags[f] && hold_cnt[f] == $past(load_len))
        else $error("overrange flag missed an exceedance");

      flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flags[f] && hold_cnt[f] > 8'h01 && !pd_sync |=> flags[f])
        else $error("overrange flag dropped before its pulse length");

      flag_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flags[f] && hold_cnt[f] == 8'h01 && !exceed[f] |=> !flags[f])
        else $error("overrange flag overstayed its pulse length");
    end
  endgenerate

  assign chan_a_over_flag_first = flags[0];
  assign chan_a_over_flag_second = flags[1];
  assign chan_b_over_flag_first = flags[2];
  assign chan_b_over_flag_second = flags[3];

  // ****************************************
  // Interrupt status
  // ****************************************
  // A new event in the clear cycle survives: set is applied after clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~irq_clear) | (exceed & ~flags & {NF{!pd_sync}});
    end
  end

  assign irq = |(status & irq_enable);

  status_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((exceed & ~flags & {NF{!pd_sync}}) != '0) |=> ((status & $past(exceed)) != '0))
    else $error("overrange event lost from status");

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response withdrawn before taken");
endmodule : ncs_top

// ### testbench/ncs_pin_model.sv
// Purpose: Model of the system logic driving the select and power-down pins
// Assumes: Pin changes bear no relation to aclk
// Notes: Pins are always driven and hold their level between calls
`timescale 1ns/10ps

module ncs_pin_model (
  output logic chan_a_osc_sel_lsb,
  output logic chan_a_osc_sel_msb,
  output logic chan_b_osc_sel_lsb,
  output logic chan_b_osc_sel_msb,
  output logic power_down_in
);
  initial begin
    {chan_a_osc_sel_msb, chan_a_osc_sel_lsb} = 2'h0;
    {chan_b_osc_sel_msb, chan_b_osc_sel_lsb} = 2'h0;
    power_down_in = 1'b0;
  end

  // Odd offset lands away from both clock edges, as an unaligned source would
  task automatic drive(input logic [1:0] a, input logic [1:0] b, input logic pd);
    #13;
    chan_a_osc_sel_lsb = a[0];
    chan_a_osc_sel_msb = a[1];
    chan_b_osc_sel_lsb = b[0];
    chan_b_osc_sel_msb = b[1];
    power_down_in = pd;
  endtask : drive
endmodule : ncs_pin_model

// ### testbench/ncs_top_tb.sv
// Purpose: Self-checking bench for oscillator select and overrange pin logic
// Assumes: AXI4-Lite master tasks; pins driven by the pin model
// Notes: Handshakes and answers taken at the rising edge, as the slave sees them
`timescale 1ns/10ps

module ncs_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, active_osc_a, active_osc_b;
  logic [31:0] s_axi_rdata, mix_phase_a, mix_phase_b, p, q;
  logic signed [11:0] sample_a = 12'h000, sample_b = 12'h000;
  logic chan_a_osc_sel_lsb, chan_a_osc_sel_msb, chan_b_osc_sel_lsb, chan_b_osc_sel_msb;
  logic power_down_in, mix_enable_a, mix_enable_b, analog_enable, serializer_enable;
  logic chan_a_over_flag_first, chan_a_over_flag_second;
  logic chan_b_over_flag_first, chan_b_over_flag_second;
  int n_fail = 0, n_tests = 0, cyc = 0, c0, e;

  ncs_top i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .chan_a_osc_sel_lsb, .chan_a_osc_sel_msb, .chan_b_osc_sel_lsb,
    .chan_b_osc_sel_msb, .power_down_in, .sample_a, .sample_b, .active_osc_a, .active_osc_b,
    .mix_phase_a, .mix_phase_b, .mix_enable_a, .mix_enable_b, .chan_a_over_flag_first,
    .chan_a_over_flag_second, .chan_b_over_flag_first, .chan_b_over_flag_second,
    .analog_enable, .serializer_enable, .irq
  );

  ncs_pin_model i_pins (
    .chan_a_osc_sel_lsb, .chan_a_osc_sel_msb, .chan_b_osc_sel_lsb, .chan_b_osc_sel_msb,
    .power_down_in
  );

  always #20 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, g, x);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic kb;
    int n;
    n = 0;
    kb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!kb && n < 50) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      kb = s_axi_bvalid;
      if (kb) chk(32'(s_axi_bresp), 32'(er));
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!kb) chk(32'h0, 32'h1);
  endtask : axi_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    logic kr;
    int n;
    n = 0;
    kr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!kr && n < 50) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      kr = s_axi_rvalid;
      if (kr) chk(s_axi_rdata, x);
      if (kr) chk(32'(s_axi_rresp), 32'(er));
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!kr) chk(32'h0, 32'h1);
  endtask : rd_chk

  // One exceeding sample, then the flag pair must hold for exactly three cycles
  task automatic pulse(input logic ch, input logic [11:0] v, input logic [1:0] x);
    logic [1:0] f;
    @(posedge aclk);
    if (ch) sample_b <= v;
    else sample_a <= v;
    @(posedge aclk);
    sample_a <= 12'h000;
    sample_b <= 12'h000;
    for (int k = 1; k <= 4; k++) begin
      #1;
      f = ch ? {chan_b_over_flag_second, chan_b_over_flag_first}
             : {chan_a_over_flag_second, chan_a_over_flag_first};
      chk(32'(f), (k <= 3) ? 32'(x) : 32'h0);
      @(posedge aclk);
    end
  endtask : pulse

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(ncs_pkg::OFF_THRESH, 32'h07ff07ff, ncs_pkg::RESP_OKAY);
    rd_chk(ncs_pkg::OFF_PULSE, 32'h1, ncs_pkg::RESP_OKAY);
    rd_chk(8'h40, 32'h0, ncs_pkg::RESP_SLVERR);
    axi_wr(ncs_pkg::OFF_STATUS, 32'hf, ncs_pkg::RESP_SLVERR);
    i_pins.drive(2'h3, 2'h2, 1'b0);
    settle(8);
    chk(32'(active_osc_a), 32'h0);
    axi_wr(ncs_pkg::OFF_FREQ_BASE + 8'h10, 32'h200, ncs_pkg::RESP_OKAY);
    axi_wr(ncs_pkg::OFF_FREQ_BASE + 8'h08, 32'h100, ncs_pkg::RESP_OKAY);
    c0 = cyc;
    axi_wr(ncs_pkg::OFF_CTRL, 32'h3, ncs_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      i_pins.drive(i[1:0], 2'(3 - i), 1'b0);
      settle(8);
      chk(32'(active_osc_a), i);
      chk(32'(active_osc_b), 3 - i);
      chk(32'(mix_enable_a), 32'h1);
    end
    i_pins.drive(2'h2, 2'h0, 1'b0);
    settle(8);
    p = mix_phase_a;
    q = mix_phase_b;
    e = cyc - c0;
    settle(1);
    chk(mix_phase_a - p, 32'h100);
    chk(mix_phase_b - q, 32'h200);
    chk(32'(p[31:8] + 4 >= e && p[31:8] <= e + 4), 32'h1);
    axi_wr(ncs_pkg::OFF_FREQ_BASE + 8'h09, 32'hffff, ncs_pkg::RESP_SLVERR);
    rd_chk(ncs_pkg::OFF_FREQ_BASE + 8'h08, 32'h100, ncs_pkg::RESP_OKAY);
    axi_wr(ncs_pkg::OFF_CTRL, 32'h1, ncs_pkg::RESP_OKAY);
    settle(2);
    chk(32'(mix_enable_a), 32'h0);
    axi_wr(ncs_pkg::OFF_CTRL, 32'h2, ncs_pkg::RESP_OKAY);
    i_pins.drive(2'h1, 2'h1, 1'b0);
    settle(8);
    chk(32'({active_osc_b, active_osc_a}), 32'h2);
    rd_chk(ncs_pkg::OFF_STATE, 32'h2, ncs_pkg::RESP_OKAY);
    axi_wr(ncs_pkg::OFF_THRESH, 32'h04000100, ncs_pkg::RESP_OKAY);
    axi_wr(ncs_pkg::OFF_PULSE, 32'h3, ncs_pkg::RESP_OKAY);
    axi_wr(ncs_pkg::OFF_IRQ_ENABLE, 32'hf, ncs_pkg::RESP_OKAY);
    pulse(1'b0, 12'h100, 2'h0);
    pulse(1'b0, 12'h200, 2'h1);
    pulse(1'b1, 12'hb00, 2'h3);
    chk(32'(irq), 32'h1);
    rd_chk(ncs_pkg::OFF_STATUS, 32'hd, ncs_pkg::RESP_OKAY);
    axi_wr(ncs_pkg::OFF_IRQ_CLEAR, 32'hf, ncs_pkg::RESP_OKAY);
    rd_chk(ncs_pkg::OFF_STATUS, 32'h0, ncs_pkg::RESP_OKAY);
    chk(32'(irq), 32'h0);
    axi_wr(ncs_pkg::OFF_IRQ_ENABLE, 32'h2, ncs_pkg::RESP_OKAY);
    pulse(1'b0, 12'h200, 2'h1);
    chk(32'(irq), 32'h0);
    pulse(1'b0, 12'h500, 2'h3);
    chk(32'(irq), 32'h1);
    i_pins.drive(2'h1, 2'h1, 1'b1);
    settle(6);
    chk(32'({analog_enable, serializer_enable, mix_enable_a}), 32'h0);
    pulse(1'b1, 12'h500, 2'h0);
    i_pins.drive(2'h1, 2'h1, 1'b0);
    settle(6);
    chk(32'({analog_enable, serializer_enable, mix_enable_b}), 32'h7);
    end_of_test;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test;
  end
endmodule : ncs_top_tb
